// File: design/dopu_top.sv
// Dual output modulator: control register, four data bytes, two outputs.
// Assumes a single-cycle special function register write/read strobe port.
`timescale 1ns/1ps
`default_nettype none
module dopu_top (
  input  wire logic       sys_clk,           // Core clock, 10 MHz
  input  wire logic       nrst,              // Async reset, active low
  input  wire logic       clk_en,            // Freezes all state when low
  input  wire logic [7:0] sfr_addr,          // Register address
  input  wire logic [7:0] sfr_wdata,         // Write data
  input  wire logic       sfr_wr,            // Write strobe, one cycle
  input  wire logic       sfr_rd,            // Read strobe, one cycle
  output logic      [7:0] sfr_rdata,         // Read data, one cycle after sfr_rd
  output logic            sfr_hit,           // Address decoded, with sfr_rdata
  input  wire logic       xtal_tick,         // Crystal-rate pulse, sys_clk domain
  input  wire logic       pll_tick,          // PLL-rate pulse, sys_clk domain
  input  wire logic       external_clock_in, // Asynchronous pin
  output logic            modulator_out_a,   // First output pin
  output logic            modulator_out_b,   // Second output pin
  output logic            outputs_active     // Pins owned by modulator
);
  logic [7:0]  ctrl, next_ctrl;
  logic [7:0]  duty_a_low_byte, duty_a_high_byte, duty_b_low_byte, duty_b_high_byte;
  logic [7:0]  next_al, next_ah, next_bl, next_bh;
  logic [7:0]  hold_a, hold_b, next_hold_a, next_hold_b;
  logic [15:0] act_a, act_b, next_act_a, next_act_b;
  logic [15:0] cnt, next_cnt;
  logic [16:0] acc_a, acc_b, next_acc_a, next_acc_b;
  logic        out_a, out_b, next_out_a, next_out_b, next_active;
  logic        phase, next_phase;
  logic [7:0]  next_rdata;
  logic        next_hit;
  logic        ext_s1, ext_s2;
  logic        tick;
  logic [2:0]  mode;
  logic        wide_mode, ctrl_wr, cycle_end;
  logic [15:0] pair_a, pair_b;
  logic [2:0]  next_mode;

  assign mode = ctrl[dopu_pkg::MODE_LSB +: 3];
  assign next_mode = next_ctrl[dopu_pkg::MODE_LSB +: 3];
  assign ctrl_wr = sfr_wr && sfr_addr == dopu_pkg::CTRL_ADDR;
  assign wide_mode = mode == dopu_pkg::M_SINGLE16 || mode == dopu_pkg::M_TWIN16
                  || mode == dopu_pkg::M_DENS16 || mode == dopu_pkg::M_DENSRZ;
  assign pair_a = {duty_a_high_byte, duty_a_low_byte};
  assign pair_b = {duty_b_high_byte, duty_b_low_byte};

  // Pin synchroniser; only the second stage is read
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
    end else if (clk_en) begin
      ext_s1 <= external_clock_in;
      ext_s2 <= ext_s1;
    end
  end

  dopu_tick_gen u_tick (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .clk_en    (clk_en),
    .clr       (ctrl_wr),
    .src_sel   (ctrl[dopu_pkg::SRC_LSB +: 2]),
    .div_sel   (ctrl[dopu_pkg::DIV_LSB +: 2]),
    .xtal_tick (xtal_tick),
    .pll_tick  (pll_tick),
    .ext_in    (ext_s2),
    .tick      (tick)
  );

  // Register file writes and reads
  always_comb begin
    next_ctrl   = ctrl;
    next_al     = duty_a_low_byte;
    next_ah     = duty_a_high_byte;
    next_bl     = duty_b_low_byte;
    next_bh     = duty_b_high_byte;
    next_hold_a = hold_a;
    next_hold_b = hold_b;
    if (sfr_wr) begin
      case (sfr_addr)
        dopu_pkg::CTRL_ADDR: next_ctrl = {1'b0, sfr_wdata[6:0] & dopu_pkg::CTRL_MASK};
        dopu_pkg::DUTY_A_L: begin
          if (wide_mode) next_hold_a = sfr_wdata;
          else next_al = sfr_wdata;
        end
        dopu_pkg::DUTY_B_L: begin
          if (wide_mode) next_hold_b = sfr_wdata;
          else next_bl = sfr_wdata;
        end
        dopu_pkg::DUTY_A_H: begin
          next_ah = sfr_wdata;
          if (wide_mode) next_al = hold_a;
        end
        dopu_pkg::DUTY_B_H: begin
          next_bh = sfr_wdata;
          if (wide_mode) next_bl = hold_b;
        end
        default: next_ctrl = ctrl;
      endcase
    end
    next_hit = sfr_rd;
    case (sfr_addr)
      dopu_pkg::CTRL_ADDR: next_rdata = ctrl;
      dopu_pkg::DUTY_A_L:  next_rdata = duty_a_low_byte;
      dopu_pkg::DUTY_A_H:  next_rdata = duty_a_high_byte;
      dopu_pkg::DUTY_B_L:  next_rdata = duty_b_low_byte;
      dopu_pkg::DUTY_B_H:  next_rdata = duty_b_high_byte;
      default: begin
        next_rdata = 8'h00;
        next_hit   = 1'b0;
      end
    endcase
    if (!sfr_rd) next_rdata = 8'h00;
  end

  // Counter, cycle-end reload of active values, output generation
  always_comb begin
    next_cnt    = cnt;
    next_act_a  = act_a;
    next_act_b  = act_b;
    next_acc_a  = acc_a;
    next_acc_b  = acc_b;
    next_out_a  = out_a;
    next_out_b  = out_b;
    next_phase  = phase;
    cycle_end   = 1'b0;
    // Ownership follows the value being written, so pins are released at once
    next_active = next_mode != dopu_pkg::M_OFF && next_mode != dopu_pkg::M_HOLD;
    case (mode)
      dopu_pkg::M_SINGLE16: cycle_end = tick && (cnt + 16'h1 >= act_b || act_b == 16'h0);
      dopu_pkg::M_TWIN8, dopu_pkg::M_DUAL8: cycle_end = tick && cnt[7:0] >= act_b[7:0];
      default: cycle_end = tick && cnt == 16'hFFFF;
    endcase
    if (tick) begin
      next_cnt = cycle_end ? 16'h0 : cnt + 16'h1;
      next_phase = ~phase;
    end
    if (cycle_end) begin
      next_act_a = pair_a;
      next_act_b = pair_b;
    end
    case (mode)
      dopu_pkg::M_SINGLE16: if (tick) next_out_a = next_cnt < act_a;
      dopu_pkg::M_TWIN8, dopu_pkg::M_DUAL8: if (tick) begin
        if (cycle_end) next_out_a = 1'b1;
        else if (next_cnt[7:0] == act_a[7:0]) next_out_a = 1'b0;
        if (next_cnt[7:0] == act_b[15:8]) next_out_b = 1'b1;
        else if (next_cnt[7:0] == act_a[15:8]) next_out_b = 1'b0;
      end
      dopu_pkg::M_TWIN16: if (tick) begin
        next_out_a = next_cnt < act_a;
        next_out_b = next_cnt < act_b;
      end
      dopu_pkg::M_DENS16, dopu_pkg::M_DENSRZ: begin
        // First-order accumulator: carry count equals data over 65536 steps
        if (tick) begin
          next_acc_a = {1'b0, acc_a[15:0]} + {1'b0, act_a};
          next_acc_b = {1'b0, acc_b[15:0]} + {1'b0, act_b};
          next_out_a = next_acc_a[16];
          next_out_b = next_acc_b[16];
        end else if (mode == dopu_pkg::M_DENSRZ) begin
          // Return to zero on the first sys_clk cycle without a tick
          next_out_a = 1'b0;
          next_out_b = 1'b0;
        end
      end
      default: begin
        next_out_a = 1'b0;
        next_out_b = 1'b0;
      end
    endcase
    if (mode == dopu_pkg::M_OFF || mode == dopu_pkg::M_HOLD) begin
      next_cnt = 16'h0;
      next_acc_a = 17'h0;
      next_acc_b = 17'h0;
      next_act_a = pair_a;
      next_act_b = pair_b;
    end
    if (ctrl_wr) begin
      next_cnt   = 16'h0;
      next_acc_a = 17'h0;
      next_acc_b = 17'h0;
      next_act_a = pair_a;
      next_act_b = pair_b;
      next_out_a = 1'b0;
      next_out_b = 1'b0;
    end
  end

  // State registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl             <= dopu_pkg::CTRL_RESET;
      duty_a_low_byte  <= dopu_pkg::DATA_RESET;
      duty_a_high_byte <= dopu_pkg::DATA_RESET;
      duty_b_low_byte  <= dopu_pkg::DATA_RESET;
      duty_b_high_byte <= dopu_pkg::DATA_RESET;
      hold_a           <= dopu_pkg::DATA_RESET;
      hold_b           <= dopu_pkg::DATA_RESET;
      act_a            <= 16'h0;
      act_b            <= 16'h0;
      cnt              <= 16'h0;
      acc_a            <= 17'h0;
      acc_b            <= 17'h0;
      out_a            <= 1'b0;
      out_b            <= 1'b0;
      phase            <= 1'b0;
      sfr_rdata        <= 8'h00;
      sfr_hit          <= 1'b0;
      modulator_out_a  <= 1'b0;
      modulator_out_b  <= 1'b0;
      outputs_active   <= 1'b0;
    end else if (clk_en) begin
      ctrl             <= next_ctrl;
      duty_a_low_byte  <= next_al;
      duty_a_high_byte <= next_ah;
      duty_b_low_byte  <= next_bl;
      duty_b_high_byte <= next_bh;
      hold_a           <= next_hold_a;
      hold_b           <= next_hold_b;
      act_a            <= next_act_a;
      act_b            <= next_act_b;
      cnt              <= next_cnt;
      acc_a            <= next_acc_a;
      acc_b            <= next_acc_b;
      out_a            <= next_out_a;
      out_b            <= next_out_b;
      phase            <= next_phase;
      sfr_rdata        <= next_rdata;
      sfr_hit          <= next_hit;
      modulator_out_a  <= next_out_a;
      modulator_out_b  <= next_out_b;
      outputs_active   <= next_active;
    end
  end
endmodule : dopu_top
`default_nettype wire

// File: design/dopu_pkg.sv
// Constants for the dual output modulator unit.
// Assumes an 8-bit special function register port on the core clock.
// Notes on behaviour
// - Bits 6..4 pick mode: off, single 16-bit, twin 8-bit, twin 16-bit.
// - Codes 4,5,6: dual 16-bit density, dual 8-bit, dual density return-to-zero.
// - Code 7 holds the counter in reset and leaves outputs unused.
// - Bits 1..0 pick clock source; bits 3..2 pick divider, top is 64.
// - Any control register write resets the counter.
// - Low byte writes in 16-bit modes go to a hidden holding register.
// - High byte write loads both bytes; outputs change from next cycle.
// - In modes 2 to 6 the two data pairs set the duty of both output pins.
// - Control bit 7 is not implemented; writes to it are ignored.
// - Single 16-bit mode: second pair is period, first pair is high time.
// - Twin 8-bit: second low byte plus one is period; compare edges per byte.
// - Twin 16-bit: full range count, high below data, both rise on rollover.
// - Density mode: over 65536 clocks output is high for data-pair clocks.
package dopu_pkg;
  localparam logic [7:0] CTRL_ADDR    = 8'hAE;
  localparam logic [7:0] DUTY_A_L     = 8'hB1;
  localparam logic [7:0] DUTY_A_H     = 8'hB2;
  localparam logic [7:0] DUTY_B_L     = 8'hB3;
  localparam logic [7:0] DUTY_B_H     = 8'hB4;
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [7:0] DATA_RESET   = 8'h00;
  localparam int         MODE_LSB     = 4;
  localparam int         DIV_LSB      = 2;
  localparam int         SRC_LSB      = 0;
  localparam logic [6:0] CTRL_MASK    = 7'h7F;
  localparam int         XTAL_DIV     = 15;
  localparam logic [2:0] M_OFF        = 3'h0;
  localparam logic [2:0] M_SINGLE16   = 3'h1;
  localparam logic [2:0] M_TWIN8      = 3'h2;
  localparam logic [2:0] M_TWIN16     = 3'h3;
  localparam logic [2:0] M_DENS16     = 3'h4;
  localparam logic [2:0] M_DUAL8      = 3'h5;
  localparam logic [2:0] M_DENSRZ     = 3'h6;
  localparam logic [2:0] M_HOLD       = 3'h7;
  localparam logic [1:0] S_XTAL15     = 2'h0;
  localparam logic [1:0] S_XTAL       = 2'h1;
  localparam logic [1:0] S_EXT        = 2'h2;
  localparam logic [1:0] S_PLL        = 2'h3;
endpackage : dopu_pkg

// File: design/dopu_tick_gen.sv
// Clock source select and prescaler producing a one-cycle counter tick.
// Assumes crystal and pll ticks are one-cycle pulses on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module dopu_tick_gen (
  input  wire logic       sys_clk,   // Core clock
  input  wire logic       nrst,      // Async reset, active low
  input  wire logic       clk_en,    // Freezes all state when low
  input  wire logic       clr,       // Restart prescalers
  input  wire logic [1:0] src_sel,   // Clock source code
  input  wire logic [1:0] div_sel,   // Divider code
  input  wire logic       xtal_tick, // Crystal pulse
  input  wire logic       pll_tick,  // PLL pulse
  input  wire logic       ext_in,    // External pin, already synchronised
  output logic            tick       // One pulse per counter step
);
  logic [3:0] xcnt, next_xcnt;
  logic [5:0] dcnt, next_dcnt;
  logic       ext_d, next_ext_d;
  logic       src_pulse;
  logic       next_tick;
  logic [5:0] div_last;

  // Source pulse, then divider; external source counts rising edges
  always_comb begin
    next_xcnt = xcnt;
    next_ext_d = ext_in;
    src_pulse = 1'b0;
    case (src_sel)
      dopu_pkg::S_XTAL15: begin
        if (xtal_tick) begin
          if (xcnt == 4'(dopu_pkg::XTAL_DIV - 1)) begin
            next_xcnt = 4'h0;
            src_pulse = 1'b1;
          end else begin
            next_xcnt = xcnt + 4'h1;
          end
        end
      end
      dopu_pkg::S_XTAL: src_pulse = xtal_tick;
      dopu_pkg::S_EXT:  src_pulse = ext_in & ~ext_d;
      dopu_pkg::S_PLL:  src_pulse = pll_tick;
      default:          src_pulse = 1'b0;
    endcase
    case (div_sel)
      2'h0:    div_last = 6'h00;
      2'h1:    div_last = 6'h03;
      2'h2:    div_last = 6'h0F;
      default: div_last = 6'h3F;
    endcase
    next_dcnt = dcnt;
    next_tick = 1'b0;
    if (src_pulse) begin
      if (dcnt >= div_last) begin
        next_dcnt = 6'h00;
        next_tick = 1'b1;
      end else begin
        next_dcnt = dcnt + 6'h01;
      end
    end
    if (clr) begin
      next_xcnt = 4'h0;
      next_dcnt = 6'h00;
      next_tick = 1'b0;
    end
  end

  // Registers only
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      xcnt  <= 4'h0;
      dcnt  <= 6'h00;
      ext_d <= 1'b0;
      tick  <= 1'b0;
    end else if (clk_en) begin
      xcnt  <= next_xcnt;
      dcnt  <= next_dcnt;
      ext_d <= next_ext_d;
      tick  <= next_tick;
    end
  end
endmodule : dopu_tick_gen
`default_nettype wire

// File: test/dopu_properties.sv
// Port assertions for the dual output modulator.
// Assumes a bind onto dopu_top, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module dopu_properties (
  input wire logic       sys_clk,         // Clock
  input wire logic       nrst,            // Reset, active low
  input wire logic       clk_en,          // Enable
  input wire logic [7:0] sfr_addr,        // Address
  input wire logic [7:0] sfr_wdata,       // Write data
  input wire logic       sfr_wr,          // Write strobe
  input wire logic       sfr_rd,          // Read strobe
  input wire logic [7:0] sfr_rdata,       // Read data
  input wire logic       sfr_hit,         // Decode hit
  input wire logic       modulator_out_a, // Pin a
  input wire logic       modulator_out_b, // Pin b
  input wire logic       outputs_active   // Pins owned
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Taken control write and the mode it carries
  logic       cw;
  logic [2:0] m;
  assign cw = sfr_wr && clk_en && (sfr_addr == dopu_pkg::CTRL_ADDR);
  assign m  = sfr_wdata[6:4];
  property p_bit7;
    sfr_rd && clk_en && sfr_addr == dopu_pkg::CTRL_ADDR |=> sfr_hit && !sfr_rdata[7];
  endproperty
  a_bit7: assert property (p_bit7) else $error("control bit 7 reads set");
  property p_clear;
    cw |=> !modulator_out_a && !modulator_out_b;
  endproperty
  a_clear: assert property (p_clear) else $error("outputs not cleared");
  property p_hold7;
    cw && m == 3'h7 |=> (!modulator_out_a && !modulator_out_b && !outputs_active)[*8];
  endproperty
  a_hold7: assert property (p_hold7) else $error("held mode drives pins");
  property p_off;
    cw && m == 3'h0 |=> (!modulator_out_a && !modulator_out_b)[*8];
  endproperty
  a_off: assert property (p_off) else $error("off mode drives pins");
  property p_on;
    cw && m != 3'h0 && m != 3'h7 |=> ##[0:1] outputs_active;
  endproperty
  a_on: assert property (p_on) else $error("active mode not owning pins");
  property p_single_b;
    cw && m == 3'h1 |=> (!modulator_out_b)[*8];
  endproperty
  a_single_b: assert property (p_single_b) else $error("pin b moves in mode 1");
  property p_stay_on;
    outputs_active && !cw |=> outputs_active;
  endproperty
  a_stay_on: assert property (p_stay_on) else $error("ownership dropped");
  property p_stay_off;
    !outputs_active && !cw && !$past(cw) |=> !outputs_active;
  endproperty
  a_stay_off: assert property (p_stay_off) else $error("ownership without write");
endmodule : dopu_properties
`default_nettype wire

// File: test/dopu_pin_model.sv
// Pin-side meter counting high cycles on both outputs.
// Assumes start is a one-cycle pulse from the bench.
`timescale 1ns/1ps
`default_nettype none
module dopu_pin_model (
  input  wire logic        sys_clk, // Clock
  input  wire logic        pin_a,   // Output a
  input  wire logic        pin_b,   // Output b
  input  wire logic        start,   // Begin window
  input  wire logic [15:0] len,     // Window cycles
  output logic             done,    // Result pulse
  output logic      [15:0] ha,      // High cycles a
  output logic      [15:0] hb       // High cycles b
);
  logic [15:0] left;
  initial begin
    left = 16'h0000;
    done = 1'b0;
  end
  // Whole-period windows make the count phase free
  always @(posedge sys_clk) begin
    done <= 1'b0;
    if (start) begin
      left <= len;
      ha   <= 16'h0000;
      hb   <= 16'h0000;
    end else if (left != 16'h0000) begin
      left <= left - 16'h0001;
      ha   <= ha + {15'h0000, pin_a};
      hb   <= hb + {15'h0000, pin_b};
      done <= (left == 16'h0001);
    end
  end
endmodule : dopu_pin_model
`default_nettype wire

// File: test/tb_dual_output_pwm_unit.sv
// Self-checking bench for the dual output modulator.
// Assumes a PLL tick every second cycle, clk_en held high.
`timescale 1ns/1ps
`default_nettype none
module tb_dual_output_pwm_unit;
  logic        sys_clk, nrst, clk_en, sfr_wr, sfr_rd, xtal_tick, pll_tick, ext_pin;
  logic        sfr_hit, out_a, out_b, active, rd_seen, m_start, m_done;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, r, lo, hi;
  logic [15:0] m_len, ha, hb;
  logic [8:0]  rq[$];
  logic [31:0] mq[$];
  logic [7:0]  ad[5] = '{8'hAE, 8'hB1, 8'hB2, 8'hB3, 8'hB4};
  int          num_errors, n_checks, cyc, i;
  dopu_top uut (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .sfr_hit(sfr_hit), .xtal_tick(xtal_tick), .pll_tick(pll_tick),
    .external_clock_in(ext_pin), .modulator_out_a(out_a), .modulator_out_b(out_b),
    .outputs_active(active));
  dopu_pin_model pins (.sys_clk(sys_clk), .pin_a(out_a), .pin_b(out_b), .start(m_start),
    .len(m_len), .done(m_done), .ha(ha), .hb(hb));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Clock sources keep running; random pin noise on the external input
  always @(posedge sys_clk) begin
    pll_tick  <= ~pll_tick;
    xtal_tick <= ($urandom % 16) == 0;
    ext_pin   <= 1'($urandom);
    rd_seen   <= sfr_rd && clk_en;
    cyc       <= cyc + 1;
    if (cyc == 40000) begin
      num_errors++;
      test_done();
    end
  end
  // Results are compared mid-cycle, after the producing edge settles
  always @(negedge sys_clk) begin
    if (rd_seen) cmp_rd(rq.pop_front());
    if (m_done) cmp_meas(mq.pop_front());
  end
  task automatic cmp_rd(input logic [8:0] e);
    n_checks++;
    if ({sfr_hit, sfr_rdata} !== e) begin
      num_errors++;
      $display("ERROR read exp %h got %h", e, {sfr_hit, sfr_rdata});
    end
  endtask : cmp_rd
  task automatic cmp_meas(input logic [31:0] e);
    n_checks++;
    if ({ha, hb} !== e) begin
      num_errors++;
      $display("ERROR high_cycles exp %h got %h", e, {ha, hb});
    end
  endtask : cmp_meas
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : idle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge sys_clk);
    sfr_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [8:0] e);
    rq.push_back(e);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge sys_clk);
    sfr_rd   <= 1'b0;
  endtask : rd
  task automatic meas(input logic [15:0] n, input logic [31:0] e);
    mq.push_back(e);
    @(posedge sys_clk);
    m_len   <= n;
    m_start <= 1'b1;
    @(posedge sys_clk);
    m_start <= 1'b0;
    idle(n + 4);
  endtask : meas
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  // Main sequence; control writes are spaced so pin checks settle
  initial begin
    {nrst, sfr_wr, sfr_rd, xtal_tick, pll_tick, ext_pin, m_start} = '0;
    {sfr_addr, sfr_wdata, m_len, rd_seen, num_errors, n_checks, cyc} = '0;
    clk_en = 1'b1;
    void'($urandom(3));
    idle(20);
    nrst <= 1'b1;
    for (i = 0; i < 5; i++) rd(ad[i], 9'h100);
    rd(8'hB0, 9'h000);
    for (i = 0; i < 8; i++) begin
      r = 8'($urandom);
      wr(ad[0], {r[7], i[2:0], r[3:0]});
      rd(ad[0], {2'h2, i[2:0], r[3:0]});
      idle(10);
    end
    wr(ad[0], 8'h33);
    idle(10);
    for (i = 0; i < 2; i++) begin
      lo = 8'($urandom);
      hi = 8'($urandom);
      wr(ad[1 + 2 * i], lo);
      rd(ad[1 + 2 * i], 9'h100);
      wr(ad[2 + 2 * i], hi);
      rd(ad[1 + 2 * i], {1'b1, lo});
      rd(ad[2 + 2 * i], {1'b1, hi});
    end
    wr(ad[0], 8'h03);
    idle(10);
    wr(ad[1], 8'h05);
    wr(ad[2], 8'h00);
    wr(ad[3], 8'h10);
    wr(ad[4], 8'h00);
    for (i = 0; i < 4; i++) begin
      wr(ad[0], {4'h1, i[1:0], 2'h3});
      // Wait past the first divided tick so the window is periodic
      idle(32 << (2 * i));
      meas(16'(320 << (2 * i)), {16'(100 << (2 * i)), 16'h0000});
    end
    // Twin 16-bit from a cleared counter: a high 4 ticks, b high 15 ticks
    wr(ad[0], 8'h33);
    meas(16'd200, {16'd8, 16'd30});
    wr(ad[0], 8'h03);
    idle(10);
    wr(ad[1], 8'h00);
    wr(ad[2], 8'h40);
    wr(ad[3], 8'h00);
    wr(ad[4], 8'h80);
    wr(ad[0], 8'h43);
    idle(10);
    meas(16'd128, {16'd32, 16'd64});
    wr(ad[0], 8'h63);
    idle(10);
    meas(16'd128, {16'd16, 16'd32});
    wr(ad[0], 8'h03);
    wr(ad[1], 8'h05);
    wr(ad[2], 8'h0A);
    wr(ad[3], 8'h0F);
    wr(ad[4], 8'h02);
    // Twin byte modes; measure only after the first wrap
    for (i = 0; i < 2; i++) begin
      wr(ad[0], {1'b0, (i[0] ? 3'h5 : 3'h2), 4'h3});
      idle(40);
      meas(16'd320, {16'd100, 16'd160});
    end
    idle(5);
    test_done();
  end
endmodule : tb_dual_output_pwm_unit
bind dopu_top dopu_properties chk (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en),
  .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .modulator_out_a(modulator_out_a),
  .modulator_out_b(modulator_out_b), .outputs_active(outputs_active));
`default_nettype wire
